// file: sis_regs.svh
// register map, field positions, reset values and timing counts of the
// system integration block; assumes an 8-bit internal bus with 16-bit addresses
`ifndef SIS_REGS_SVH
`define SIS_REGS_SVH
`define SIS_ADDR_BREAK_STATUS 16'hfe00
`define SIS_ADDR_RESET_CAUSE 16'hfe01
`define SIS_ADDR_BREAK_FLAG_CTRL 16'hfe03
`define SIS_ADDR_IRQ_LOW 16'hfe04
`define SIS_ADDR_IRQ_MID 16'hfe05
`define SIS_ADDR_IRQ_HIGH 16'hfe06
`define SIS_BIT_BREAK_EXITED_WAIT 1
`define SIS_BIT_BREAK_CLEAR_ENABLE 7
`define SIS_RESET_VALUE 8'h00
`define SIS_STOP_RECOVERY_LONG 4096
`define SIS_STOP_RECOVERY_SHORT 32
`endif

// file: sis_pkg.sv
// types shared by the system integration block
// assumes sis_regs.svh for all numeric constants
package sis_pkg;
  typedef enum logic [1:0] {SIS_RUN, SIS_WAIT, SIS_STOP, SIS_RECOVER} sis_mode_t;
  typedef struct packed {
    logic por;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch_address;
    logic low_voltage;
  } sis_reset_src_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sis_bus_t;
endpackage : sis_pkg

// file: sis_core.sv
// system integration: pending-irq status, reset cause, break control,
// wait/stop low-power sequencing with stop recovery counter.
// assumes cpu bus strobes are synchronous to REF_CLK; reset sources are
// already synchronous pulses held until RST releases.
// Contract
// - status flag mirrors pending request
// - low status: sources 6..1, bits 1..0 zero
// - mid status: sources 14..7 in bits 7..0
// - high status: sources 16,15, bits 7..2 zero
// - resets share top priority, no arbitration
// - break forces software interrupt vector fetch
// - break flag clearing only with enable set
// - flag cleared in break stays cleared
// - two-step clear protected across break entry
// - wait and stop clear interrupt mask
// - wait gates cpu clock, peripherals run
// - wait wake stacks one cycle later
// - break or reset exits wait; break sets flag
// - watchdog runs in wait unless disabled
// - stop disables bus and crystal clocks
// - stop exits by irq/reset/break after recovery
// - recovery 4096 cycles, or 32 if short
// - counter held in stop, then counts recovery
// - reset cause holds six source flags
// - reading reset cause clears it
// - power-on sets por, clears others
// - bad address flag only for fetches
// - flag numbers follow source priority order
`timescale 1ns/100ps
`include "sis_regs.svh"

module sis_core
  import sis_pkg::*;
#(
  parameter int RECOVERY_LONG = `SIS_STOP_RECOVERY_LONG,
  parameter int RECOVERY_SHORT = `SIS_STOP_RECOVERY_SHORT
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // register bus
  input wire logic BUS_RD,
  input wire logic BUS_WR,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [7:0] BUS_WDATA,
  output logic [7:0] BUS_RDATA,
  // interrupt sources, index 0 is source 1 in priority order
  input wire logic [15:0] IRQ_PENDING,
  // reset causes captured on reset entry
  input wire logic RESET_POR,
  input wire logic RESET_PIN,
  input wire logic RESET_WATCHDOG,
  input wire logic RESET_BAD_OPCODE,
  input wire logic RESET_BAD_FETCH,
  input wire logic RESET_FETCH_CYCLE,
  input wire logic RESET_LOW_VOLTAGE,
  // cpu and break
  input wire logic WAIT_EXEC,
  input wire logic STOP_EXEC,
  input wire logic BREAK_REQ,
  input wire logic BREAK_ACTIVE,
  input wire logic FLAG_CLEAR_REQ,
  input wire logic SHORT_RECOVERY_OPTION,
  input wire logic WATCHDOG_DISABLE_OPTION,
  output logic CLEAR_IRQ_MASK,
  output logic FORCE_SWI_VECTOR,
  output logic STACK_START,
  output logic FLAG_CLEAR_ALLOW,
  output logic CPU_CLOCK_EN,
  output logic BUS_CLOCK_OUT_EN,
  output logic CRYSTAL_CLOCK_EN,
  output logic WATCHDOG_RUN,
  output logic SYS_RESET_OUT
);

  sis_mode_t mode;
  sis_mode_t next_mode;
  sis_reset_src_t cause;
  sis_reset_src_t next_cause;
  logic [7:0] irq_low;
  logic [7:0] irq_mid;
  logic [7:0] irq_high;
  logic [11:0] sim_count;
  logic [11:0] next_sim_count;
  logic break_exited_wait_flag;
  logic break_clear_enable;
  logic any_reset;
  logic irq_any;
  logic wake_wait;
  logic wake_stop;
  logic recovery_done;
  logic [11:0] recovery_last;
  logic [7:0] next_rdata;
  logic sel_break_status;
  logic sel_reset_cause;
  logic sel_flag_ctrl;
  logic sel_irq_low;
  logic sel_irq_mid;
  logic sel_irq_high;
  logic rd_cause;

  // all reset causes act alike, no priority among them
  assign any_reset = RESET_POR | RESET_PIN | RESET_WATCHDOG | RESET_BAD_OPCODE
    | RESET_BAD_FETCH | RESET_LOW_VOLTAGE;

  // status layout; requests are live, never latched
  assign irq_low = {IRQ_PENDING[5:0], 2'b00};
  assign irq_mid = IRQ_PENDING[13:6];
  assign irq_high = {6'b000000, IRQ_PENDING[15:14]};
  assign irq_any = |IRQ_PENDING;

  // address decode
  assign sel_break_status = BUS_ADDR == `SIS_ADDR_BREAK_STATUS;
  assign sel_reset_cause = BUS_ADDR == `SIS_ADDR_RESET_CAUSE;
  assign sel_flag_ctrl = BUS_ADDR == `SIS_ADDR_BREAK_FLAG_CTRL;
  assign sel_irq_low = BUS_ADDR == `SIS_ADDR_IRQ_LOW;
  assign sel_irq_mid = BUS_ADDR == `SIS_ADDR_IRQ_MID;
  assign sel_irq_high = BUS_ADDR == `SIS_ADDR_IRQ_HIGH;
  assign rd_cause = BUS_RD & sel_reset_cause;

  assign next_rdata =
    sel_break_status ? {6'b000000, break_exited_wait_flag, 1'b0} :
    sel_reset_cause ? {cause, 2'b00} :
    sel_flag_ctrl ? {break_clear_enable, 7'b0000000} :
    sel_irq_low ? irq_low :
    sel_irq_mid ? irq_mid :
    sel_irq_high ? irq_high : `SIS_RESET_VALUE;

  // a new cause wins over a read clear in the same cycle
  assign next_cause = RESET_POR ? sis_reset_src_t'(6'b100000) :
    (rd_cause ? sis_reset_src_t'(6'b000000) : cause) |
    {1'b0, RESET_PIN, RESET_WATCHDOG, RESET_BAD_OPCODE,
     RESET_BAD_FETCH & RESET_FETCH_CYCLE, RESET_LOW_VOLTAGE};

  assign recovery_last = SHORT_RECOVERY_OPTION ? 12'(RECOVERY_SHORT - 1)
    : 12'(RECOVERY_LONG - 1);
  assign recovery_done = mode == SIS_RECOVER && sim_count == recovery_last;
  assign wake_wait = irq_any | BREAK_REQ | any_reset;
  assign wake_stop = irq_any | BREAK_REQ | any_reset;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      SIS_RUN:
      begin
        if (STOP_EXEC)
        begin
          next_mode = SIS_STOP;
        end
        else if (WAIT_EXEC)
        begin
          next_mode = SIS_WAIT;
        end
      end
      SIS_WAIT:
      begin
        if (wake_wait)
        begin
          next_mode = SIS_RUN;
        end
      end
      SIS_STOP:
      begin
        if (wake_stop)
        begin
          next_mode = SIS_RECOVER;
        end
      end
      SIS_RECOVER:
      begin
        if (recovery_done)
        begin
          next_mode = SIS_RUN;
        end
      end
      default:
      begin
        next_mode = SIS_RUN;
      end
    endcase
  end

  // counter cleared while stopped and on the cycle that enters stop, counts otherwise
  assign next_sim_count = (mode == SIS_STOP || next_mode == SIS_STOP) ? 12'h000 :
    sim_count + 12'h001;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      mode <= SIS_RUN;
      sim_count <= 12'h000;
    end
    else
    begin
      mode <= next_mode;
      sim_count <= next_sim_count;
    end
  end

  // reset cause is not cleared by RST so it survives the reset it reports
  always_ff @(posedge REF_CLK)
  begin
    cause <= next_cause;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      break_exited_wait_flag <= 1'b0;
      break_clear_enable <= 1'b0;
      BUS_RDATA <= `SIS_RESET_VALUE;
    end
    else
    begin
      BUS_RDATA <= BUS_RD ? next_rdata : `SIS_RESET_VALUE;
      if (mode == SIS_WAIT && BREAK_REQ)
      begin
        break_exited_wait_flag <= 1'b1;
      end
      else if (BUS_WR && sel_break_status && !BUS_WDATA[`SIS_BIT_BREAK_EXITED_WAIT])
      begin
        break_exited_wait_flag <= 1'b0;
      end
      if (BUS_WR && sel_flag_ctrl)
      begin
        break_clear_enable <= BUS_WDATA[`SIS_BIT_BREAK_CLEAR_ENABLE];
      end
      // writes to the irq status addresses fall through untouched
    end
  end

  // outputs, all registered
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      CLEAR_IRQ_MASK <= 1'b0;
      FORCE_SWI_VECTOR <= 1'b0;
      STACK_START <= 1'b0;
      FLAG_CLEAR_ALLOW <= 1'b1;
      CPU_CLOCK_EN <= 1'b1;
      BUS_CLOCK_OUT_EN <= 1'b1;
      CRYSTAL_CLOCK_EN <= 1'b1;
      WATCHDOG_RUN <= 1'b0;
      SYS_RESET_OUT <= 1'b1;
    end
    else
    begin
      CLEAR_IRQ_MASK <= mode == SIS_RUN && (WAIT_EXEC || STOP_EXEC);
      FORCE_SWI_VECTOR <= BREAK_REQ;
      STACK_START <= (mode == SIS_WAIT && irq_any && !any_reset) ||
        (recovery_done && irq_any);
      // per-module flag clearing only passes when not in break or enabled;
      // the second step of a two-step clear is gated too, so an early first
      // step cannot complete inside break
      FLAG_CLEAR_ALLOW <= !BREAK_ACTIVE || break_clear_enable;
      CPU_CLOCK_EN <= next_mode == SIS_RUN;
      BUS_CLOCK_OUT_EN <= next_mode != SIS_STOP;
      CRYSTAL_CLOCK_EN <= next_mode != SIS_STOP;
      WATCHDOG_RUN <= !WATCHDOG_DISABLE_OPTION && next_mode != SIS_STOP;
      SYS_RESET_OUT <= any_reset;
    end
  end

  // helper for the recovery length checks; a counter, since 4096 repeats would not unroll
  logic [12:0] recover_cycles;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      recover_cycles <= 13'h0000;
    end
    else if (mode == SIS_RECOVER)
    begin
      recover_cycles <= recover_cycles + 13'h0001;
    end
    else
    begin
      recover_cycles <= 13'h0000;
    end
  end

  // assertions
  a_wait_mask_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_RUN && WAIT_EXEC |=> CLEAR_IRQ_MASK)
    else $error("mask not cleared on wait");
  a_wait_cpu_gated: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_WAIT |-> !CPU_CLOCK_EN && BUS_CLOCK_OUT_EN)
    else $error("wait clock gating wrong");
  a_wait_wake_stack: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_WAIT && irq_any && !any_reset |=> STACK_START)
    else $error("stacking not one cycle after wake");
  a_break_sets_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_WAIT && BREAK_REQ |=> break_exited_wait_flag && mode == SIS_RUN)
    else $error("break exit of wait not flagged");
  a_wait_watchdog: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_WAIT && !WATCHDOG_DISABLE_OPTION |-> WATCHDOG_RUN)
    else $error("watchdog stopped in wait");
  a_break_swi: assert property (@(posedge REF_CLK) disable iff (RST)
    BREAK_REQ |=> FORCE_SWI_VECTOR)
    else $error("break did not force swi vector");
  a_reset_out: assert property (@(posedge REF_CLK) disable iff (RST)
    any_reset |=> SYS_RESET_OUT)
    else $error("reset source not passed on");
  a_stop_clocks_off: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_STOP |-> !BUS_CLOCK_OUT_EN && !CRYSTAL_CLOCK_EN)
    else $error("clocks running in stop");
  a_recovery_length: assert property (@(posedge REF_CLK) disable iff (RST)
    $fell(mode == SIS_RECOVER) |-> recover_cycles == (SHORT_RECOVERY_OPTION ?
      13'(RECOVERY_SHORT) : 13'(RECOVERY_LONG)))
    else $error("stop recovery length wrong");
  a_recovery_bound: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_RECOVER |-> recover_cycles < (SHORT_RECOVERY_OPTION ?
      13'(RECOVERY_SHORT) : 13'(RECOVERY_LONG)))
    else $error("stop recovery overran");
  a_stop_counter_held: assert property (@(posedge REF_CLK) disable iff (RST)
    mode == SIS_STOP |=> sim_count == 12'h000)
    else $error("counter not held in stop");
  a_flag_guard: assert property (@(posedge REF_CLK) disable iff (RST)
    BREAK_ACTIVE && !break_clear_enable |=> !FLAG_CLEAR_ALLOW)
    else $error("flag clear allowed in break");
  a_cause_read_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    rd_cause && !any_reset |=> cause == sis_reset_src_t'(6'b000000))
    else $error("reset cause not cleared by read");
  a_por_only: assert property (@(posedge REF_CLK)
    RESET_POR |=> cause == sis_reset_src_t'(6'b100000))
    else $error("power-on cause wrong");
  a_fetch_only_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    RESET_BAD_FETCH && !RESET_FETCH_CYCLE && !RESET_POR && !cause.bad_fetch_address
    |=> !cause.bad_fetch_address)
    else $error("bad address flag set by data access");
  a_irq_low_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    BUS_RD && sel_irq_low |=> BUS_RDATA[1:0] == 2'b00
      && BUS_RDATA[7:2] == $past(IRQ_PENDING[5:0]))
    else $error("low irq status layout wrong");
  a_irq_high_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    BUS_RD && sel_irq_high |=> BUS_RDATA == {6'b000000, $past(IRQ_PENDING[15:14])})
    else $error("high irq status layout wrong");
  c_wait_wake: cover property (@(posedge REF_CLK) mode == SIS_WAIT ##1 STACK_START);
  c_stop_recover: cover property (@(posedge REF_CLK) recovery_done);
  c_break_in_wait: cover property (@(posedge REF_CLK) mode == SIS_WAIT && BREAK_REQ);
  c_clear_blocked: cover property (@(posedge REF_CLK)
    BREAK_ACTIVE && FLAG_CLEAR_REQ && !FLAG_CLEAR_ALLOW);
  c_long_recover: cover property (@(posedge REF_CLK) recovery_done && !SHORT_RECOVERY_OPTION);

endmodule : sis_core

// file: sis_periph_model.sv
// peripheral-side model: holds pending requests and drops them on a clear while clear_allow is high
// assumes one-cycle set and clear strobes from the bench
`timescale 1ns/100ps
module sis_periph_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // strobes from the bench
  input wire logic [15:0] set_req,
  input wire logic [15:0] clr_req,
  // gate and requests
  input wire logic clear_allow,
  output logic [15:0] irq_pending
);
  // a clear without the gate leaves the flag set, as real peripherals do
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_pending <= 16'h0000;
    else
      irq_pending <= (irq_pending | set_req) & ~(clr_req & {16{clear_allow}});
  end
endmodule : sis_periph_model

// file: tb.sv
// self-checking bench for sis_core with a peripheral model
// assumes reads answer one cycle after the strobe
`timescale 1ns/100ps
`include "sis_regs.svh"
module tb
  import sis_pkg::*;
;
  localparam int REC_LONG = 64; // long recovery shortened to keep the run brief
  logic clk, rst, rd_seen, por, pin, wdg, bop, bfa, fcy, lv, wx, sx, brq, bact, srec, wdd;
  logic cim, software_interrupt, stk, allow, cpu_en, bus_en, xtal_en, wdg_run, sro;
  logic [7:0] rdata;
  logic [15:0] irq, set_req, clr_req, v;
  sis_bus_t bus;
  logic [7:0] expq[$];
  int fail_count, n_tests, n_cim, k;
  sis_core #(.RECOVERY_LONG(REC_LONG), .RECOVERY_SHORT(32)) u_dut (.REF_CLK(clk), .RST(rst),
    .BUS_RD(bus.rd), .BUS_WR(bus.wr), .BUS_ADDR(bus.addr), .BUS_WDATA(bus.wdata),
    .BUS_RDATA(rdata), .IRQ_PENDING(irq), .RESET_POR(por), .RESET_PIN(pin),
    .RESET_WATCHDOG(wdg), .RESET_BAD_OPCODE(bop), .RESET_BAD_FETCH(bfa),
    .RESET_FETCH_CYCLE(fcy), .RESET_LOW_VOLTAGE(lv), .WAIT_EXEC(wx), .STOP_EXEC(sx),
    .BREAK_REQ(brq), .BREAK_ACTIVE(bact), .FLAG_CLEAR_REQ(|clr_req),
    .SHORT_RECOVERY_OPTION(srec), .WATCHDOG_DISABLE_OPTION(wdd), .CLEAR_IRQ_MASK(cim),
    .FORCE_SWI_VECTOR(software_interrupt), .STACK_START(stk), .FLAG_CLEAR_ALLOW(allow),
    .CPU_CLOCK_EN(cpu_en), .BUS_CLOCK_OUT_EN(bus_en), .CRYSTAL_CLOCK_EN(xtal_en),
    .WATCHDOG_RUN(wdg_run), .SYS_RESET_OUT(sro));
  sis_periph_model u_per (.clk(clk), .rst(rst), .set_req(set_req), .clr_req(clr_req),
    .clear_allow(allow), .irq_pending(irq));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // a quiet cycle after each access so no strobe is set twice in one step
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    bus.rd = !w;
    bus.wr = w;
    bus.addr = a;
    bus.wdata = d;
    cyc(1);
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    cyc(1);
  endtask : acc
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask : rd
  task automatic pulse(input logic [15:0] s, input logic [15:0] c);
    set_req = s;
    clr_req = c;
    cyc(1);
    set_req = 16'h0000;
    clr_req = 16'h0000;
    cyc(1);
  endtask : pulse
  task automatic wait_stack(input int lo, input int hi);
    int c;
    c = 0;
    while (stk !== 1'b1 && c <= hi)
    begin
      cyc(1);
      c++;
    end
    chk("stack delay in range", 1'b1, c >= lo && c <= hi);
    if (c > hi)
      finish_test();
  endtask : wait_stack
  task automatic irq_reads(input logic [15:0] x);
    rd(`SIS_ADDR_IRQ_LOW, {x[5:0], 2'b00});
    rd(`SIS_ADDR_IRQ_MID, x[13:6]);
    rd(`SIS_ADDR_IRQ_HIGH, {6'h00, x[15:14]});
  endtask : irq_reads
  always @(posedge clk) rd_seen <= bus.rd;
  // counted on the falling edge, half a cycle after launch, so the pulse is settled
  always @(negedge clk) if (cim === 1'b1) n_cim++;
  always @(negedge clk)
    if (rd_seen === 1'b1 && expq.size() > 0)
      chk("read data", expq.pop_front(), {8'h00, rdata});
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
  initial
  begin
    k = $urandom(32'hc236b087);
    {rst, por, pin, wdg, bop, bfa, fcy, lv, wx, sx, brq, bact, srec, wdd} = 14'h3000;
    bus = '0;
    set_req = 16'h0000;
    clr_req = 16'h0000;
    cyc(4);
    rst = 1'b0;
    por = 1'b0;
    rd(`SIS_ADDR_RESET_CAUSE, 8'h80);
    rd(`SIS_ADDR_RESET_CAUSE, 8'h00);
    fcy = 1'b1;
    for (k = 0; k < 6; k++)
    begin
      {por, pin, wdg, bop, bfa, lv} = 6'h20 >> k;
      cyc(1);
      chk("reset out", 1'b1, sro);
      {por, pin, wdg, bop, bfa, lv} = 6'h00;
      rd(`SIS_ADDR_RESET_CAUSE, 8'h80 >> k);
    end
    fcy = 1'b0;
    bfa = 1'b1;
    cyc(1);
    bfa = 1'b0;
    rd(`SIS_ADDR_RESET_CAUSE, 8'h00);
    pin = 1'b1;
    cyc(1);
    {por, pin} = 2'b10;
    cyc(1);
    por = 1'b0;
    rd(`SIS_ADDR_RESET_CAUSE, 8'h80);
    v = 16'($urandom());
    pulse(v, 16'h0000);
    irq_reads(v);
    for (k = 4; k < 7; k++)
      acc(1'b1, 16'hfe00 + 16'(k), 8'hff);
    irq_reads(v);
    pulse(16'h0000, 16'hffff);
    irq_reads(16'h0000);
    acc(1'b1, `SIS_ADDR_BREAK_FLAG_CTRL, 8'h00);
    bact = 1'b1;
    pulse(16'h0001, 16'h0000);
    chk("clear allow", 1'b0, allow);
    pulse(16'h0000, 16'hffff);
    rd(`SIS_ADDR_IRQ_LOW, 8'h04);
    acc(1'b1, `SIS_ADDR_BREAK_FLAG_CTRL, 8'h80);
    rd(`SIS_ADDR_BREAK_FLAG_CTRL, 8'h80);
    pulse(16'h0000, 16'hffff);
    bact = 1'b0;
    cyc(2);
    rd(`SIS_ADDR_IRQ_LOW, 8'h00);
    brq = 1'b1;
    cyc(1);
    chk("swi vector", 1'b1, software_interrupt);
    brq = 1'b0;
    cyc(2);
    chk("swi vector", 1'b0, software_interrupt);
    wx = 1'b1;
    cyc(1);
    wx = 1'b0;
    cyc(2);
    chk("cpu clock", 1'b0, cpu_en);
    chk("peripheral clock", 1'b1, bus_en);
    chk("watchdog run", 1'b1, wdg_run);
    set_req = 16'h0100;
    cyc(1);
    set_req = 16'h0000;
    wait_stack(1, 3);
    pulse(16'h0000, 16'hffff);
    wdd = 1'b1;
    wx = 1'b1;
    cyc(1);
    wx = 1'b0;
    cyc(2);
    chk("watchdog off", 1'b0, wdg_run);
    brq = 1'b1;
    cyc(1);
    brq = 1'b0;
    wdd = 1'b0;
    cyc(2);
    chk("cpu clock", 1'b1, cpu_en);
    rd(`SIS_ADDR_BREAK_STATUS, 8'h02);
    acc(1'b1, `SIS_ADDR_BREAK_STATUS, 8'h00);
    for (k = 0; k < 2; k++)
    begin
      srec = (k == 0);
      sx = 1'b1;
      cyc(1);
      sx = 1'b0;
      cyc(2);
      chk("bus clock", 1'b0, bus_en);
      chk("crystal clock", 1'b0, xtal_en);
      set_req = 16'h8000;
      cyc(1);
      set_req = 16'h0000;
      wait_stack(k ? REC_LONG : 32, (k ? REC_LONG : 32) + 4);
      pulse(16'h0000, 16'hffff);
    end
    chk("mask clears", 16'd4, 16'(n_cim));
    finish_test();
  end
endmodule : tb
